// file: cmp_pkg.sv
// package: register offsets, field positions, reset values for the
// comparator and ladder reference control block.
// assumes an apb slave with 32-bit data, one word per register.
package cmp_pkg;
  localparam logic [7:0] ADDR_CMP_A = 8'h00;
  localparam logic [7:0] ADDR_CMP_B = 8'h04;
  localparam logic [7:0] ADDR_LADDER = 8'h08;
  localparam logic [7:0] ADDR_WAKE = 8'h0c;
  // comparator control fields
  localparam int BIT_RESULT = 7;
  localparam int BIT_PIN_DRIVE_N = 6;
  localparam int BIT_NONINVERT = 5;
  localparam int BIT_TMR_SEL_N = 4;
  localparam int BIT_POS_HI = 4;
  localparam int BIT_ENABLE = 3;
  localparam int BIT_NEG_SEL = 2;
  localparam int BIT_POS_SEL = 1;
  localparam int BIT_WAKE_DIS = 0;
  // ladder control fields
  localparam int BIT_LAD_EN = 7;
  localparam int BIT_LAD_PIN = 6;
  localparam int BIT_LAD_LOW = 5;
  localparam int BIT_LAD_GAP = 4;
  localparam logic [6:0] CMP_CTRL_RST = 7'h7f;
  localparam logic [7:0] LADDER_RST = 8'h20;
  localparam logic [7:0] LADDER_WMASK = 8'hef;
endpackage

// file: cmp_sync_if.sv
// interface: synchronised comparator raw results into the top.
// assumes one clock domain.
`timescale 1ns/1ps
interface cmp_sync_if;
  logic raw_a;
  logic raw_b;
  modport src (output raw_a, output raw_b);
  modport dst (input raw_a, input raw_b);
endinterface

// file: pin_sync3.sv
// module: three-stage synchroniser with a filter that waits for stages two and three to agree.
// assumes an asynchronous level from an analog comparator.
`timescale 1ns/1ps
module pin_sync3 (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_ff, s2_ff, s3_ff, level_ff;
  // ---------------------------------------------
  // sync chain; first stage feeds second only
  // ---------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // change counts once stages two and three agree
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
  assign level_o = level_ff;
endmodule

// file: cmp_sync_pair.sv
// module: synchronises both comparator raw results onto the interface.
// assumes raw analog outputs arrive asynchronously.
`timescale 1ns/1ps
module cmp_sync_pair (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic cmp_a_raw_i,
  input wire logic cmp_b_raw_i,
  cmp_sync_if.src sync
);
  pin_sync3 u_a (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .async_i(cmp_a_raw_i),
    .level_o(sync.raw_a)
  );
  pin_sync3 u_b (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .async_i(cmp_b_raw_i),
    .level_o(sync.raw_b)
  );
endmodule

// file: cmp_vref_ctrl.sv
// top: apb control of two comparators and a 32-level ladder reference.
// assumes analog comparators and ladder live outside; raw results are
// asynchronous and pass a 3-stage synchroniser.
//
// How it works
// - pin_drive_n low puts result on pin
// - routed result overrides pin direction
// - noninvert set passes, clear inverts result
// - cleared timer select clocks timer from A
// - comparator powered only while enable set
// - B negative: pin or internal ladder
// - B upper positive: A pos or B neg
// - wake_disable set blocks wake on change
// - enabled selected pins forced analog input
// - disabling returns pins to stored settings
// - ladder: 16 steps times two ranges
// - range bit picks ladder equation
// - ladder off draws no current
// - ladder pin_drive overrides pin direction
// - result bit read-only, writes ignored
// - wake flag sets on change after read
// - reset returns control registers to defaults
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cmp_vref_ctrl
  import cmp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog comparator raw outputs (pos above neg)
  input wire logic cmp_a_raw_i,
  input wire logic cmp_b_raw_i,
  // analog control
  output logic cmp_a_enable_o,
  output logic cmp_b_enable_o,
  output logic cmp_a_pos_from_pin_o,
  output logic cmp_a_neg_from_pin_o,
  output logic cmp_b_neg_from_pin_o,
  output logic cmp_b_pos_from_pin_o,
  output logic cmp_b_pos_from_a_o,
  output logic ladder_enable_o,
  output logic ladder_low_range_o,
  output logic [3:0] ladder_step_code_o,
  // pin overrides
  output logic cmp_a_pin_drive_o,
  output logic cmp_b_pin_drive_o,
  output logic cmp_a_result_pin_o,
  output logic cmp_b_result_pin_o,
  output logic ladder_pin_drive_o,
  output logic [4:0] analog_force_o,
  // timer and wake
  output logic timer_zero_from_cmp_o,
  output logic timer_zero_cmp_clk_o,
  output logic compare_wake_flag_o
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [6:0] cmp_a_ff, cmp_b_ff;
  logic [7:0] ladder_ff;
  logic wake_flag_ff;
  logic latched_a_ff, latched_b_ff, armed_ff;
  logic [31:0] prdata_ff;
  logic out_a_en_ff, out_b_en_ff, pin_a_ff, pin_b_ff, lad_pin_ff;
  logic res_a_pin_ff, res_b_pin_ff;
  logic tmr_sel_ff, tmr_clk_ff, lad_en_ff, lad_low_ff;
  logic [3:0] lad_code_ff;
  logic a_on_ff, b_on_ff;
  logic a_pp_ff, a_np_ff, b_np_ff, b_pp_ff, b_pa_ff;
  logic [4:0] force_ff;

  cmp_sync_if sync_bus ();
  cmp_sync_pair u_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .cmp_a_raw_i(cmp_a_raw_i),
    .cmp_b_raw_i(cmp_b_raw_i),
    .sync(sync_bus.src)
  );

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i;
  wire rd = access & ~pwrite_i;
  wire hit_a = (paddr_i == ADDR_CMP_A);
  wire hit_b = (paddr_i == ADDR_CMP_B);
  wire hit_l = (paddr_i == ADDR_LADDER);
  wire hit_w = (paddr_i == ADDR_WAKE);
  wire mapped = hit_a | hit_b | hit_l | hit_w;

  // ---------------------------------------------
  // result path
  // ---------------------------------------------
  // comparator off; result held low when disabled
  wire a_on = cmp_a_ff[BIT_ENABLE];
  wire b_on = cmp_b_ff[BIT_ENABLE];
  // polarity applied before report and routing
  // raw high means positive above negative
  wire res_a = a_on & (sync_bus.raw_a ~^ cmp_a_ff[BIT_NONINVERT]);
  wire res_b = b_on & (sync_bus.raw_b ~^ cmp_b_ff[BIT_NONINVERT]);

  // result bit comes from logic, not storage
  wire [7:0] rd_a = {res_a, cmp_a_ff};
  wire [7:0] rd_b = {res_b, cmp_b_ff};
  wire [7:0] rd_l = ladder_ff;
  wire [7:0] rd_mux = hit_a ? rd_a : hit_b ? rd_b : hit_l ? rd_l :
                      hit_w ? {7'h00, wake_flag_ff} : 8'h00;

  // ---------------------------------------------
  // input routing and analog override
  // ---------------------------------------------
  // B negative: pin when set, ladder when clear
  wire b_neg_pin = cmp_b_ff[BIT_NEG_SEL];
  // upper positive picks A pos or B neg pin
  wire b_pos_hi = cmp_b_ff[BIT_POS_HI];
  wire b_pos_pin = cmp_b_ff[BIT_POS_SEL];
  wire a_pos_pin = cmp_a_ff[BIT_POS_SEL];
  wire a_neg_pin = cmp_a_ff[BIT_NEG_SEL];
  // force selected pins analog while enabled
  // drop force when disabled; stored settings untouched
  // pins: 0 a_pos, 1 a_neg, 2 b_pos, 3 b_neg, 4 ladder pin
  wire [4:0] force_next = {
    ladder_ff[BIT_LAD_PIN],
    b_on & (b_neg_pin | (~b_pos_pin & ~b_pos_hi)),
    b_on & b_pos_pin,
    (a_on & ~a_pos_pin) | (a_on & a_neg_pin),
    (a_on & a_pos_pin) | (b_on & ~b_pos_pin & b_pos_hi)
  };

  // wake allowed per comparator when bit clear
  wire wake_a_ok = ~cmp_a_ff[BIT_WAKE_DIS];
  wire wake_b_ok = ~cmp_b_ff[BIT_WAKE_DIS];
  // change versus latched state after a read
  wire changed = armed_ff & ((wake_a_ok & (res_a != latched_a_ff)) |
                             (wake_b_ok & (res_b != latched_b_ff)));
  wire rd_ctrl = rd & (hit_a | hit_b);
  wire clr_flag = wr & hit_w & ~pwdata_i[0];

  // ---------------------------------------------
  // control registers
  // ---------------------------------------------
  // reset restores control defaults
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_a_ff <= CMP_CTRL_RST;
      cmp_b_ff <= CMP_CTRL_RST;
      ladder_ff <= LADDER_RST;
    end else begin
      // bit seven of write data dropped for comparators; ladder writes drop bit four
      if (wr & hit_a) begin
        cmp_a_ff <= pwdata_i[6:0];
      end
      if (wr & hit_b) begin
        cmp_b_ff <= pwdata_i[6:0];
      end
      if (wr & hit_l) begin
        ladder_ff <= pwdata_i[7:0] & LADDER_WMASK;
      end
    end
  end

  // wake flag: set wins over software clear
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_flag_ff <= 1'b0;
      armed_ff <= 1'b0;
      latched_a_ff <= 1'b0;
      latched_b_ff <= 1'b0;
    end else begin
      // read latches state and arms detector
      if (rd_ctrl) begin
        latched_a_ff <= res_a;
        latched_b_ff <= res_b;
        armed_ff <= 1'b1;
      end
      if (changed) begin
        wake_flag_ff <= 1'b1;
      end else if (clr_flag) begin
        wake_flag_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // apb answer; zero wait states
  // ---------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------------------------------------
  // registered outputs
  // ---------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_a_en_ff <= 1'b0;
      out_b_en_ff <= 1'b0;
      res_a_pin_ff <= 1'b0;
      res_b_pin_ff <= 1'b0;
      lad_pin_ff <= 1'b0;
      tmr_sel_ff <= 1'b0;
      tmr_clk_ff <= 1'b0;
      lad_en_ff <= 1'b0;
      lad_low_ff <= 1'b0;
      lad_code_ff <= 4'h0;
      a_on_ff <= 1'b0;
      b_on_ff <= 1'b0;
      a_pp_ff <= 1'b0;
      a_np_ff <= 1'b0;
      b_np_ff <= 1'b0;
      b_pp_ff <= 1'b0;
      b_pa_ff <= 1'b0;
      force_ff <= 5'h00;
    end else begin
      out_a_en_ff <= ~cmp_a_ff[BIT_PIN_DRIVE_N];
      out_b_en_ff <= ~cmp_b_ff[BIT_PIN_DRIVE_N];
      res_a_pin_ff <= res_a;
      res_b_pin_ff <= res_b;
      // ladder onto its pin, direction overridden
      lad_pin_ff <= ladder_ff[BIT_LAD_PIN];
      // cleared select routes A to timer clock
      tmr_sel_ff <= ~cmp_a_ff[BIT_TMR_SEL_N];
      tmr_clk_ff <= res_a;
      lad_en_ff <= ladder_ff[BIT_LAD_EN];
      // range and step code to ladder
      lad_low_ff <= ladder_ff[BIT_LAD_LOW];
      lad_code_ff <= ladder_ff[3:0];
      a_on_ff <= a_on;
      b_on_ff <= b_on;
      a_pp_ff <= a_pos_pin;
      a_np_ff <= a_neg_pin;
      b_np_ff <= b_neg_pin;
      b_pp_ff <= b_pos_pin;
      b_pa_ff <= b_pos_hi;
      force_ff <= force_next;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign cmp_a_enable_o = a_on_ff;
  assign cmp_b_enable_o = b_on_ff;
  assign cmp_a_pos_from_pin_o = a_pp_ff;
  assign cmp_a_neg_from_pin_o = a_np_ff;
  assign cmp_b_neg_from_pin_o = b_np_ff;
  assign cmp_b_pos_from_pin_o = b_pp_ff;
  assign cmp_b_pos_from_a_o = b_pa_ff;
  assign ladder_enable_o = lad_en_ff;
  assign ladder_low_range_o = lad_low_ff;
  assign ladder_step_code_o = lad_code_ff;
  assign cmp_a_pin_drive_o = out_a_en_ff;
  assign cmp_b_pin_drive_o = out_b_en_ff;
  assign cmp_a_result_pin_o = res_a_pin_ff;
  assign cmp_b_result_pin_o = res_b_pin_ff;
  assign ladder_pin_drive_o = lad_pin_ff;
  assign analog_force_o = force_ff;
  assign timer_zero_from_cmp_o = tmr_sel_ff;
  assign timer_zero_cmp_clk_o = tmr_clk_ff;
  assign compare_wake_flag_o = wake_flag_ff;
endmodule

// file: cmp_vref_ctrl_assertions.sv
// checker: port timing of the comparator and ladder control block.
// assumes zero-wait apb and outputs one edge after their register.
`timescale 1ns/1ps
module cmp_vref_ctrl_assertions
  import cmp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic cmp_a_enable_o,
  input wire logic cmp_b_enable_o,
  input wire logic cmp_a_result_pin_o,
  input wire logic cmp_b_pin_drive_o,
  input wire logic ladder_low_range_o,
  input wire logic [3:0] ladder_step_code_o,
  input wire logic [4:0] analog_force_o,
  input wire logic timer_zero_from_cmp_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // write strobes for comparator a, b and ladder registers, read strobe
  wire logic acc_w = psel_i & penable_i & pwrite_i;
  wire logic acc_r = psel_i & penable_i & ~pwrite_i;
  wire logic wr_a = acc_w & (paddr_i == ADDR_CMP_A);
  wire logic wr_b = acc_w & (paddr_i == ADDR_CMP_B);
  wire logic wr_l = acc_w & (paddr_i == ADDR_LADDER);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_ready_fixed: assert property (pready_o && !pslverr_o)
    else $error("apb answer not zero-wait okay");
  a_enable_follows: assert property (wr_a |-> ##2
    cmp_a_enable_o == $past(pwdata_i[BIT_ENABLE], 2))
    else $error("comparator a enable mismatch");
  a_timer_select: assert property (wr_a |-> ##2
    timer_zero_from_cmp_o == !$past(pwdata_i[BIT_TMR_SEL_N], 2))
    else $error("timer source select mismatch");
  a_pin_drive_b: assert property (wr_b |-> ##2
    cmp_b_pin_drive_o == !$past(pwdata_i[BIT_PIN_DRIVE_N], 2))
    else $error("comparator b pin drive mismatch");
  a_ladder_step: assert property (wr_l |-> ##2
    ladder_step_code_o == $past(pwdata_i[3:0], 2) &&
    ladder_low_range_o == $past(pwdata_i[BIT_LAD_LOW], 2))
    else $error("ladder step or range mismatch");
  a_result_off: assert property (!cmp_a_enable_o |->
    !cmp_a_result_pin_o)
    else $error("result shown while comparator off");
  // b's upper positive select may still hold the a pos pin
  a_force_off_a: assert property (!cmp_a_enable_o &&
    !cmp_b_enable_o |-> analog_force_o[1:0] == 2'h0)
    else $error("pins a forced while off");
  a_force_off_b: assert property (!cmp_b_enable_o |->
    analog_force_o[3:2] == 2'h0)
    else $error("pins b forced while off");
  a_gap_zero: assert property (acc_r && paddr_i == ADDR_LADDER |->
    !prdata_o[BIT_LAD_GAP])
    else $error("ladder spare bit reads one");
  a_read_upper: assert property (acc_r |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule

// file: cmp_vref_ctrl_test.sv
// testbench: apb master driving the comparator control block.
// assumes zero-wait apb slave and raw comparator inputs from here.
`timescale 1ns/1ps
module cmp_vref_ctrl_test;
  import cmp_pkg::*;
  logic core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic cmp_a_raw_i, cmp_b_raw_i, pready_o, pslverr_o, ra, rb;
  logic cmp_a_enable_o, cmp_b_enable_o, cmp_a_pos_from_pin_o;
  logic cmp_a_neg_from_pin_o, cmp_b_neg_from_pin_o, cmp_b_pos_from_pin_o;
  logic cmp_b_pos_from_a_o, ladder_enable_o, ladder_low_range_o;
  logic cmp_a_pin_drive_o, cmp_b_pin_drive_o, cmp_a_result_pin_o;
  logic cmp_b_result_pin_o, ladder_pin_drive_o, timer_zero_from_cmp_o;
  logic timer_zero_cmp_clk_o, compare_wake_flag_o;
  logic [3:0] ladder_step_code_o;
  logic [4:0] analog_force_o;
  logic [7:0] a, d;
  int error_cnt = 0;
  int tests_run = 0;
  cmp_vref_ctrl dut (.core_clk_i, .arst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .cmp_a_raw_i, .cmp_b_raw_i, .cmp_a_enable_o, .cmp_b_enable_o,
    .cmp_a_pos_from_pin_o, .cmp_a_neg_from_pin_o, .cmp_b_neg_from_pin_o,
    .cmp_b_pos_from_pin_o, .cmp_b_pos_from_a_o, .ladder_enable_o,
    .ladder_low_range_o, .ladder_step_code_o, .cmp_a_pin_drive_o,
    .cmp_b_pin_drive_o, .cmp_a_result_pin_o, .cmp_b_result_pin_o,
    .ladder_pin_drive_o, .analog_force_o, .timer_zero_from_cmp_o,
    .timer_zero_cmp_clk_o, .compare_wake_flag_o);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one transfer; waits on pready with a bound, never assumes latency
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      end_of_test();
    end
    r = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // result bit: raw passed when noninvert set, zero while off
  function automatic logic res_of(input logic [7:0] v, input logic raw);
    return v[BIT_ENABLE] & (raw ^ ~v[BIT_NONINVERT]);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] ad, v,
                                         input logic raw);
    if (ad == ADDR_LADDER) return {24'h0, v & 8'hef};
    if (ad == ADDR_CMP_A || ad == ADDR_CMP_B)
      return {24'h0, res_of(v, raw), v[6:0]};
    return 32'h0;
  endfunction
  // reset with raws low, then check defaults
  task automatic do_reset;
    arst_n_i <= 1'b0;
    cmp_a_raw_i <= 1'b0;
    cmp_b_raw_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    apb(0, ADDR_CMP_A, 32'h0);
    check("reset a", 32'h7f, r);
    apb(0, ADDR_CMP_B, 32'h0);
    check("reset b", 32'h7f, r);
    apb(0, ADDR_LADDER, 32'h0);
    check("reset ladder", 32'h20, r);
    check("reset drive", 2'h0, {cmp_a_pin_drive_o, cmp_b_pin_drive_o});
    $display("test reset done");
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {arst_n_i, cmp_a_raw_i, cmp_b_raw_i} = '0;
    void'($urandom(32'h818c5211));
    do_reset();
    // random writes with corners first; upper data bits set on purpose
    for (int i = 0; i < 24; i++) begin
      a = (i % 3 == 0) ? ADDR_CMP_A : (i % 3 == 1) ? ADDR_CMP_B : ADDR_LADDER;
      d = (i < 3) ? 8'hff : (i < 6) ? 8'h00 : 8'($urandom);
      ra = 1'($urandom);
      rb = 1'($urandom);
      cmp_a_raw_i <= ra;
      cmp_b_raw_i <= rb;
      apb(1, a, {24'hffffff, d});
      repeat (8) @(posedge core_clk_i);
      apb(0, a, 32'h0);
      check("readback", exp_rd(a, d, a == ADDR_CMP_B ? rb : ra), r);
      if (a == ADDR_CMP_A)
        check("ctrl a", {d[3], ~d[4], ~d[6], res_of(d, ra), d[2:1],
          res_of(d, ra)},
          {cmp_a_enable_o, timer_zero_from_cmp_o, cmp_a_pin_drive_o,
           cmp_a_result_pin_o, cmp_a_neg_from_pin_o,
           cmp_a_pos_from_pin_o, timer_zero_cmp_clk_o});
      else if (a == ADDR_CMP_B)
        check("ctrl b", {d[3], ~d[6], res_of(d, rb), d[2], d[1], d[4]},
          {cmp_b_enable_o, cmp_b_pin_drive_o, cmp_b_result_pin_o,
           cmp_b_neg_from_pin_o, cmp_b_pos_from_pin_o,
           cmp_b_pos_from_a_o});
      else
        check("ladder", {d[7:5], d[3:0], d[6]}, {ladder_enable_o,
          ladder_pin_drive_o, ladder_low_range_o,
          ladder_step_code_o, analog_force_o[4]});
    end
    apb(1, 8'h10, 32'hff);
    apb(0, 8'h10, 32'h0);
    check("unmapped", 32'h0, r);
    $display("test random done");
    // wake: a armed and enabled, b enabled with wake disabled
    cmp_a_raw_i <= 1'b0;
    cmp_b_raw_i <= 1'b0;
    apb(1, ADDR_CMP_A, 32'h3a);
    apb(1, ADDR_CMP_B, 32'h39);
    repeat (8) @(posedge core_clk_i);
    check("force on", 2'h1, analog_force_o[1:0]);
    // relatch first: a stale latched state would set the flag again
    apb(0, ADDR_CMP_A, 32'h0);
    apb(1, ADDR_WAKE, 32'h0);
    cmp_b_raw_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    apb(0, ADDR_WAKE, 32'h0);
    check("wake blocked", 32'h0, r);
    cmp_a_raw_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    apb(0, ADDR_WAKE, 32'h0);
    check("wake set", 32'h1, r);
    apb(0, ADDR_CMP_A, 32'h0);
    apb(1, ADDR_WAKE, 32'h0);
    apb(0, ADDR_WAKE, 32'h0);
    check("wake clear", 2'h0, {r[0], compare_wake_flag_o});
    apb(1, ADDR_CMP_A, 32'h32);
    repeat (3) @(posedge core_clk_i);
    // b still on with upper select: a pos pin stays forced
    check("force off", 2'h1, analog_force_o[1:0]);
    apb(1, ADDR_CMP_B, 32'h31);
    repeat (3) @(posedge core_clk_i);
    check("force off b", 4'h0, analog_force_o[3:0]);
    $display("test wake done");
    do_reset();
    end_of_test();
  end
endmodule
bind cmp_vref_ctrl cmp_vref_ctrl_assertions u_chk (.core_clk_i, .arst_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .cmp_a_enable_o, .cmp_b_enable_o,
  .cmp_a_result_pin_o, .cmp_b_pin_drive_o, .ladder_low_range_o,
  .ladder_step_code_o, .analog_force_o, .timer_zero_from_cmp_o);
